/* File: logic/sopc_regs.sv */
// Sync output and line-PLL configuration register bank
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Extra blanked lines around vertical blanking from 2-bit field, default two.
// - Line PLL time constant fixed at 0, automatic at 1.
// - Sync delay selection applies only while shift enable is set; the code outputs zero delay for every setting.
// - Shift enable 0 gives undelayed sync; 1 delays sync; the code never delays sync.
// - Sync-to-SAV alignment honoured only when bit set and analog mode.
// - Alignment bit 0 gives analog-mode sync timing.
// - Effective alignment: sync low on first SAV byte, high on last.
// - High noise disables phase jumps and copy-protection detection.
// - Cursor 000 forces high noise, 111 low, else proportion of measured; the code judges high noise for every other cursor.
// - Measured noise level is readable and is the cursor reference.
// - Each register takes its listed reset value.
module sopc_regs (
  // Clock and reset
  input  wire  logic       core_clk_i,
  input  wire  logic       rst_i,
  // Register port (byte wide)
  input  wire  logic       reg_wr_i,
  input  wire  logic [7:0] reg_addr_i,
  input  wire  logic [7:0] reg_wdata_i,
  output var   logic [7:0] reg_rdata_o,
  // Video status from the decoder core
  input  wire  logic       analog_mode_i,
  input  wire  logic [7:0] noise_level_i,
  input  wire  logic       sav_first_i,
  input  wire  logic       sav_last_i,
  input  wire  logic       analog_sync_n_i,
  // Control outputs
  output var   logic [1:0] extra_blank_lines_o,
  output var   logic       pll_time_constant_sel_o,
  output var   logic [1:0] line_sync_delay_o,
  output var   logic       line_sync_n_o,
  output var   logic       high_noise_o,
  output var   logic       phase_jump_enable_o,
  output var   logic       copy_prot_det_enable_o
);
  import sopc_pkg::*;

  // ==========================================================================
  // Storage
  logic [7:0] blank_ff, pllmode_ff, rsvd_a_ff, pjump_ff, syncnz_ff, rsvd_b_ff;
  logic [7:0] rdata_ff;
  logic [1:0] blank_out_ff, delay_out_ff;
  logic       tc_ff, sync_n_ff, hinoise_ff, pj_ff, cp_ff;

  // ==========================================================================
  // Decode
  wire logic       wr_blank   = reg_wr_i && (reg_addr_i == SOPC_ADDR_BLANK);
  wire logic       wr_pllmode = reg_wr_i && (reg_addr_i == SOPC_ADDR_PLLMODE);
  wire logic       wr_rsvd_a  = reg_wr_i && (reg_addr_i == SOPC_ADDR_RSVD_A);
  wire logic       wr_pjump   = reg_wr_i && (reg_addr_i == SOPC_ADDR_PJUMP);
  wire logic       wr_syncnz  = reg_wr_i && (reg_addr_i == SOPC_ADDR_SYNCNZ);
  wire logic       wr_rsvd_b  = reg_wr_i && (reg_addr_i == SOPC_ADDR_RSVD_B);

  // Readback mux; unmapped offsets read zero
  logic [7:0] nxt_rdata;
  always_comb begin
    if (reg_addr_i == SOPC_ADDR_BLANK)        nxt_rdata = blank_ff;
    else if (reg_addr_i == SOPC_ADDR_PLLMODE) nxt_rdata = pllmode_ff;
    else if (reg_addr_i == SOPC_ADDR_RSVD_A)  nxt_rdata = rsvd_a_ff;
    else if (reg_addr_i == SOPC_ADDR_PJUMP)   nxt_rdata = pjump_ff;
    else if (reg_addr_i == SOPC_ADDR_SYNCNZ)  nxt_rdata = syncnz_ff;
    else if (reg_addr_i == SOPC_ADDR_RSVD_B)  nxt_rdata = rsvd_b_ff;
    else if (reg_addr_i == SOPC_ADDR_NZSTAT)  nxt_rdata = noise_level_i;
    else                                      nxt_rdata = SOPC_UNMAPPED;
  end

  // ==========================================================================
  // Noise judgement
  // Threshold = measured level scaled by cursor/8; product fits in 11 bits
  wire logic [2:0]  cursor    = syncnz_ff[SOPC_CUR_MSB:SOPC_CUR_LSB];
  wire logic [10:0] scaled    = noise_level_i * cursor;
  wire logic [7:0]  threshold = scaled[10:3];
  wire logic        nxt_hinoise =
      (cursor == SOPC_CUR_FORCE_HI) ? 1'b1 :
      (cursor == SOPC_CUR_FORCE_LO) ? 1'b0 :
      (noise_level_i >= threshold);

  // ==========================================================================
  // Sync alignment
  wire logic sav_effective = syncnz_ff[SOPC_SAV_BIT] && analog_mode_i;
  // Alignment holds last SAV edge; otherwise analog timing passes through
  wire logic nxt_sync_n =
      !sav_effective ? analog_sync_n_i :
      sav_first_i    ? 1'b0 :
      sav_last_i     ? 1'b1 : sync_n_ff;

  // Delay codes not yet defined, so every code maps to zero delay
  wire logic [1:0] nxt_delay =
      pllmode_ff[SOPC_SHEN_BIT] ? SOPC_DEL_ZERO : SOPC_DEL_ZERO;

  // ==========================================================================
  // Registers written by software
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_ff   <= SOPC_RST_BLANK;
      pllmode_ff <= SOPC_RST_PLLMODE;
      rsvd_a_ff  <= SOPC_RST_RSVD_A;
      pjump_ff   <= SOPC_RST_PJUMP;
      syncnz_ff  <= SOPC_RST_SYNCNZ;
      rsvd_b_ff  <= SOPC_RST_RSVD_B;
    end else begin
      if (wr_blank)   blank_ff   <= reg_wdata_i;
      if (wr_pllmode) pllmode_ff <= reg_wdata_i;
      if (wr_rsvd_a)  rsvd_a_ff  <= reg_wdata_i;
      if (wr_pjump)   pjump_ff   <= reg_wdata_i;
      if (wr_syncnz)  syncnz_ff  <= reg_wdata_i;
      if (wr_rsvd_b)  rsvd_b_ff  <= reg_wdata_i;
    end
  end

  // Output flops; reset values follow the register defaults, except high noise, which resets low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff     <= SOPC_UNMAPPED;
      blank_out_ff <= SOPC_RST_BLANK[SOPC_BLK_MSB:SOPC_BLK_LSB];
      tc_ff        <= SOPC_RST_PLLMODE[SOPC_TC_BIT];
      delay_out_ff <= SOPC_DEL_ZERO;
      sync_n_ff    <= 1'b1;
      hinoise_ff   <= 1'b0;
      pj_ff        <= 1'b0;
      cp_ff        <= 1'b0;
    end else begin
      rdata_ff     <= nxt_rdata;
      blank_out_ff <= blank_ff[SOPC_BLK_MSB:SOPC_BLK_LSB];
      tc_ff        <= pllmode_ff[SOPC_TC_BIT];
      delay_out_ff <= nxt_delay;
      sync_n_ff    <= nxt_sync_n;
      hinoise_ff   <= nxt_hinoise;
      pj_ff        <= !nxt_hinoise;
      cp_ff        <= !nxt_hinoise;
    end
  end

  assign reg_rdata_o             = rdata_ff;
  assign extra_blank_lines_o     = blank_out_ff;
  assign pll_time_constant_sel_o = tc_ff;
  assign line_sync_delay_o       = delay_out_ff;
  assign line_sync_n_o           = sync_n_ff;
  assign high_noise_o            = hinoise_ff;
  assign phase_jump_enable_o     = pj_ff;
  assign copy_prot_det_enable_o  = cp_ff;

  // ==========================================================================
  // Checks
  a_blank_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_blank |-> ##2 extra_blank_lines_o == $past(reg_wdata_i[5:4], 2))
    else $error("blank lines field not applied");
  a_tc_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_pllmode |-> ##2 pll_time_constant_sel_o == $past(reg_wdata_i[3], 2))
    else $error("time constant mode not applied");
  a_delay_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    line_sync_delay_o == SOPC_DEL_ZERO)
    else $error("sync delay nonzero");
  a_sync_pass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !sav_effective |=> line_sync_n_o == $past(analog_sync_n_i))
    else $error("analog sync not passed");
  a_sav_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sav_effective && sav_first_i) |=> !line_sync_n_o)
    else $error("sync not low on SAV first byte");
  a_sav_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sav_effective && !sav_first_i && sav_last_i) |=> line_sync_n_o)
    else $error("sync not high on SAV last byte");
  a_noise_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    high_noise_o |-> !phase_jump_enable_o && !copy_prot_det_enable_o)
    else $error("features on under high noise");
  a_cursor_hi: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cursor == SOPC_CUR_FORCE_HI) |=> high_noise_o)
    else $error("cursor 000 not forcing high noise");
  a_cursor_lo: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cursor == SOPC_CUR_FORCE_LO) |=> !high_noise_o)
    else $error("cursor 111 not forcing low noise");
  a_stat_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_addr_i == SOPC_ADDR_NZSTAT) |=> reg_rdata_o == $past(noise_level_i))
    else $error("noise status readback wrong");
endmodule : sopc_regs
`default_nettype wire

/* File: pkg/sopc_pkg.sv */
// Package: register map, field positions and reset values of the sync/PLL bank
package sopc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SOPC_ADDR_BLANK   = 8'h21;
  localparam logic [7:0] SOPC_ADDR_PLLMODE = 8'h22;
  localparam logic [7:0] SOPC_ADDR_RSVD_A  = 8'h23;
  localparam logic [7:0] SOPC_ADDR_PJUMP   = 8'h24;
  localparam logic [7:0] SOPC_ADDR_SYNCNZ  = 8'h25;
  localparam logic [7:0] SOPC_ADDR_RSVD_B  = 8'h26;
  localparam logic [7:0] SOPC_ADDR_NZSTAT  = 8'h2F;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] SOPC_RST_BLANK    = 8'h2B;
  localparam logic [7:0] SOPC_RST_PLLMODE  = 8'hE8;
  localparam logic [7:0] SOPC_RST_RSVD_A   = 8'hAA;
  localparam logic [7:0] SOPC_RST_PJUMP    = 8'h87;
  localparam logic [7:0] SOPC_RST_SYNCNZ   = 8'h94;
  localparam logic [7:0] SOPC_RST_RSVD_B   = 8'h44;
  localparam logic [7:0] SOPC_UNMAPPED     = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int SOPC_BLK_LSB   = 4;
  localparam int SOPC_BLK_MSB   = 5;
  localparam int SOPC_TC_BIT    = 3;
  localparam int SOPC_DEL_LSB   = 1;
  localparam int SOPC_DEL_MSB   = 2;
  localparam int SOPC_SHEN_BIT  = 0;
  localparam int SOPC_SAV_BIT   = 3;
  localparam int SOPC_CUR_LSB   = 0;
  localparam int SOPC_CUR_MSB   = 2;
  // Cursor extremes and zero delay code
  localparam logic [2:0] SOPC_CUR_FORCE_HI = 3'h0;
  localparam logic [2:0] SOPC_CUR_FORCE_LO = 3'h7;
  localparam logic [1:0] SOPC_DEL_ZERO     = 2'h0;
endpackage : sopc_pkg

/* File: verification/test_sync_output_pll_config.sv */
// Self-checking bench for the sync output and line-PLL register bank
`timescale 1ns/100ps
`default_nettype none
module test_sync_output_pll_config;
  import sopc_pkg::*;
  // ==========================================================================
  // Stimulus, observed outputs and bookkeeping
  logic       core_clk_i, rst_i, reg_wr_i, analog_mode_i;
  logic       sav_first_i, sav_last_i, analog_sync_n_i;
  logic [7:0] reg_addr_i, reg_wdata_i, noise_level_i, reg_rdata_o, v, f;
  logic [1:0] blank_o, delay_o;
  logic       tc_o, sync_n_o, high_o, pj_o, cp_o;
  int         n_errors, samples_checked, cycles, seed, k;
  sopc_regs i_sopc_regs (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .analog_mode_i(analog_mode_i),
    .noise_level_i(noise_level_i), .sav_first_i(sav_first_i),
    .sav_last_i(sav_last_i), .analog_sync_n_i(analog_sync_n_i),
    .extra_blank_lines_o(blank_o), .pll_time_constant_sel_o(tc_o),
    .line_sync_delay_o(delay_o), .line_sync_n_o(sync_n_o),
    .high_noise_o(high_o), .phase_jump_enable_o(pj_o),
    .copy_prot_det_enable_o(cp_o));
  // ==========================================================================
  // Expectations; mid-range cursors always judge high noise in this design
  function automatic logic exp_high(input logic [2:0] cur);
    return cur !== SOPC_CUR_FORCE_LO;
  endfunction : exp_high
  function automatic logic [7:0] exp_rst(input logic [7:0] a);
    case (a)
      SOPC_ADDR_BLANK:   return SOPC_RST_BLANK;
      SOPC_ADDR_PLLMODE: return SOPC_RST_PLLMODE;
      SOPC_ADDR_RSVD_A:  return SOPC_RST_RSVD_A;
      SOPC_ADDR_PJUMP:   return SOPC_RST_PJUMP;
      SOPC_ADDR_SYNCNZ:  return SOPC_RST_SYNCNZ;
      default:           return SOPC_RST_RSVD_B;
    endcase
  endfunction : exp_rst
  // ==========================================================================
  // Shared tasks; every task starts and ends just after a rising edge
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i = a;
    tick(1);
    d = reg_rdata_o;
  endtask : rd
  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h0BE7;
    {reg_wr_i, reg_addr_i, reg_wdata_i, sav_first_i, sav_last_i} = '0;
    {analog_mode_i, analog_sync_n_i} = 2'b01;
    noise_level_i = $random(seed);
    rst_i = 1'b1;
    tick(5);
    rst_i = 1'b0;
    check("reset blank lines", {6'h00, blank_o}, 8'h02);
    for (k = 8'h21; k <= 8'h26; k++) begin
      rd(k[7:0], v);
      check("reset value", v, exp_rst(k[7:0]));
    end
    wr(SOPC_ADDR_NZSTAT, ~noise_level_i);
    rd(8'h30, v);
    check("unmapped read", v, SOPC_UNMAPPED);
    rd(SOPC_ADDR_NZSTAT, v);
    check("noise status", v, noise_level_i);
    wr(SOPC_ADDR_RSVD_A, 8'hAA);
    wr(SOPC_ADDR_PJUMP, 8'h87);
    wr(SOPC_ADDR_RSVD_B, 8'h44);
    // Random fields, first two passes pin the cursor extremes
    for (k = 0; k < 16; k++) begin
      f = $random(seed);
      if (k < 2) f[2:0] = k[0] ? SOPC_CUR_FORCE_LO : SOPC_CUR_FORCE_HI;
      wr(SOPC_ADDR_BLANK, {2'b00, k[1:0], 4'hB});
      wr(SOPC_ADDR_PLLMODE, {4'hE, f[7:4]});
      wr(SOPC_ADDR_SYNCNZ, {4'h9, 1'b0, f[2:0]});
      rd(SOPC_ADDR_BLANK, v);
      check("blank reg", v, {2'b00, k[1:0], 4'hB});
      rd(SOPC_ADDR_PLLMODE, v);
      check("pll mode reg", v, {4'hE, f[7:4]});
      rd(SOPC_ADDR_SYNCNZ, v);
      check("sync noise reg", v, {5'h12, f[2:0]});
      check("blank lines", {6'h00, blank_o}, {6'h00, k[1:0]});
      check("time constant", {7'h00, tc_o}, {7'h00, f[7]});
      check("sync delay", {6'h00, delay_o}, {6'h00, SOPC_DEL_ZERO});
      check("high noise", {7'h00, high_o}, {7'h00, exp_high(f[2:0])});
      check("jump detect", {6'h00, pj_o, cp_o}, {6'h00, {2{~exp_high(f[2:0])}}});
    end
    // Alignment off, then on in digital mode: sync tracks analog timing
    wr(SOPC_ADDR_SYNCNZ, 8'h97);
    for (k = 0; k < 4; k++) begin
      analog_sync_n_i = k[0];
      tick(2);
      check("analog sync", {7'h00, sync_n_o}, {7'h00, k[0]});
    end
    wr(SOPC_ADDR_SYNCNZ, 8'h9F);
    analog_mode_i = 1'b0;
    analog_sync_n_i = 1'b1;
    tick(2);
    check("digital mode sync", {7'h00, sync_n_o}, 8'h01);
    // Effective alignment: analog sync ignored, SAV bytes give the edges
    analog_mode_i = 1'b1;
    analog_sync_n_i = 1'b0;
    tick(3);
    check("sync holds", {7'h00, sync_n_o}, 8'h01);
    {sav_first_i, sav_last_i} = 2'b11;
    tick(1);
    sav_first_i = 1'b0;
    check("sav first", {7'h00, sync_n_o}, 8'h00);
    tick(1);
    sav_last_i = 1'b0;
    check("sav last", {7'h00, sync_n_o}, 8'h01);
    give_verdict();
  end
endmodule : test_sync_output_pll_config
`default_nettype wire
